// ### pkg/scl_pkg.sv
package scl_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned SETTLE_NS     = 1000;
  localparam int unsigned SOFT_RST_NS   = 2000;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SOFT_RST_CYC  = (SOFT_RST_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W         = 8;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_RSTCTL    = 12'h01f;
  localparam logic [11:0] IDX_LPCFG     = 12'h18b;
  localparam logic [11:0] IDX_STRAPSTS  = 12'h45d;
  localparam logic [11:0] IDX_OVERRIDE  = 12'h460;
  localparam int unsigned ADDR_W        = 14;

  localparam int unsigned RSTCTL_HW_BIT = 15;
  localparam int unsigned LP_REL_BIT    = 6;
  localparam int unsigned OV_HOSTIF_LSB = 0;
  localparam int unsigned OV_ROLE_BIT   = 3;
  localparam int unsigned OV_AUTO_BIT   = 4;
  localparam int unsigned OV_EN_HOSTIF  = 8;
  localparam int unsigned OV_EN_ROLE    = 9;
  localparam int unsigned OV_EN_AUTO    = 10;

  // Strap pin sample vector positions
  localparam int unsigned SP_CTRL_LO = 0;
  localparam int unsigned SP_CTRL_HI = 1;
  localparam int unsigned SP_ER_LO   = 2;
  localparam int unsigned SP_ER_HI   = 3;
  localparam int unsigned SP_RXD0    = 4;
  localparam int unsigned SP_RXD3    = 7;
  localparam int unsigned SP_IND0    = 8;
  localparam int unsigned SP_IND1    = 9;
  localparam int unsigned SP_CLKPIN  = 10;
  localparam int unsigned SP_RSTN    = 11;
  localparam int unsigned SP_W       = 12;

  typedef enum logic [1:0] {
    SCL_MODE1 = 2'h1,
    SCL_MODE2 = 2'h2,
    SCL_MODE3 = 2'h3
  } scl_mode_t;

  typedef enum logic [2:0] {
    SCL_IF_SERIAL   = 3'h0,
    SCL_IF_MII      = 3'h1,
    SCL_IF_RMII_FOL = 3'h2,
    SCL_IF_RMII_LDR = 3'h3,
    SCL_IF_RGMII_AL = 3'h4,
    SCL_IF_RGMII_TX = 3'h5,
    SCL_IF_RGMII_TR = 3'h6,
    SCL_IF_RGMII_RX = 3'h7
  } scl_hostif_t;

  typedef enum logic [1:0] {
    SCL_ST_HOLD   = 2'h0,
    SCL_ST_SETTLE = 2'h1,
    SCL_ST_RUN    = 2'h3
  } scl_state_t;

  typedef struct packed {
    logic [3:0]  station_addr_bits;
    scl_hostif_t host_if_select;
    logic        clock_out_pin_select;
    logic        leader_follower_select;
    logic        auto_disable;
  } scl_cfg_t;

  localparam scl_cfg_t CFG_RESET = '{4'h0, SCL_IF_SERIAL, 1'b0, 1'b0, 1'b0};

endpackage

// ### rtl/scl_strap_latch.sv
// Added by the designer: the register offsets and the APB slave port.
module scl_strap_latch #(
  parameter bit HAS_SERIAL = 1'b1
) (
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 reset_pin_n,
  input  wire logic                 rx_ctrl_above_low,
  input  wire logic                 rx_ctrl_above_high,
  input  wire logic                 rx_er_above_low,
  input  wire logic                 rx_er_above_high,
  input  wire logic [3:0]           rx_data_strap,
  input  wire logic                 indicator0_pin_i,
  input  wire logic                 indicator1_pin_i,
  input  wire logic                 clock_output_pin_i,
  input  wire logic                 clock_src,
  input  wire logic                 indicator1_src,
  input  wire logic                 link_up,
  output logic                      indicator1_pin_o,
  output logic                      indicator1_pin_oe_n,
  output logic                      clock_output_pin_o,
  output logic                      clock_output_pin_oe_n,
  output logic                      strap_phase,
  output logic [3:0]                station_addr_bits,
  output scl_pkg::scl_hostif_t      host_if_select,
  output logic                      host_if_reserved,
  output logic                      clock_out_pin_select,
  output logic                      leader_follower_select,
  output logic                      auto_disable,
  output logic                      link_start_enable
);

  // Three-stage synchronisers on every strap input
  logic [scl_pkg::SP_W-1:0] pin_raw;
  logic [scl_pkg::SP_W-1:0] sync1_reg;
  logic [scl_pkg::SP_W-1:0] sync2_reg;
  logic [scl_pkg::SP_W-1:0] sync3_reg;
  logic [scl_pkg::SP_W-1:0] pin_reg;

  assign pin_raw = {reset_pin_n, clock_output_pin_i, indicator1_pin_i, indicator0_pin_i,
                    rx_data_strap, rx_er_above_high, rx_er_above_low,
                    rx_ctrl_above_high, rx_ctrl_above_low};

  genvar gi;
  generate
    for (gi = 0; gi < scl_pkg::SP_W; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (srst) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          sync3_reg[gi] <= 1'b0;
          pin_reg[gi]   <= 1'b0;
        end else begin
          sync1_reg[gi] <= pin_raw[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          sync3_reg[gi] <= sync2_reg[gi];
          if (sync2_reg[gi] == sync3_reg[gi]) begin
            pin_reg[gi] <= sync3_reg[gi];
          end
        end
      end
    end
  endgenerate

  // Comparator pair to strap mode: open pin reads mode 1
  function automatic scl_pkg::scl_mode_t level3(input logic above_low, input logic above_high);
    if (above_high) begin
      level3 = scl_pkg::SCL_MODE3;
    end else if (above_low) begin
      level3 = scl_pkg::SCL_MODE2;
    end else begin
      level3 = scl_pkg::SCL_MODE1;
    end
  endfunction

  // Strap decode
  scl_pkg::scl_mode_t ctrl_mode;
  scl_pkg::scl_mode_t er_mode;
  logic [3:0]         addr_dec;
  logic               clksel_dec;
  logic               auto_dec;
  scl_pkg::scl_cfg_t  strap_dec;

  assign ctrl_mode = level3(pin_reg[scl_pkg::SP_CTRL_LO], pin_reg[scl_pkg::SP_CTRL_HI]);
  assign er_mode   = level3(pin_reg[scl_pkg::SP_ER_LO], pin_reg[scl_pkg::SP_ER_HI]);
  assign addr_dec[0] = (ctrl_mode == scl_pkg::SCL_MODE3);
  assign addr_dec[2] = (ctrl_mode != scl_pkg::SCL_MODE1);
  assign addr_dec[1] = (er_mode == scl_pkg::SCL_MODE3);
  assign addr_dec[3] = (er_mode != scl_pkg::SCL_MODE1);
  assign clksel_dec  = pin_reg[scl_pkg::SP_RXD3];
  // Source pin chosen from the freshly resolved selection
  assign auto_dec    = clksel_dec ? pin_reg[scl_pkg::SP_CLKPIN]
                                  : pin_reg[scl_pkg::SP_IND1];

  assign strap_dec.station_addr_bits      = addr_dec;
  assign strap_dec.host_if_select         = scl_pkg::scl_hostif_t'(pin_reg[scl_pkg::SP_RXD0 +: 3]);
  assign strap_dec.clock_out_pin_select   = clksel_dec;
  assign strap_dec.leader_follower_select = pin_reg[scl_pkg::SP_IND0];
  assign strap_dec.auto_disable           = auto_dec;

  // Reset sequencing
  scl_pkg::scl_state_t               state_reg;
  scl_pkg::scl_state_t               state_next;
  logic [scl_pkg::CNT_W-1:0]         settle_cnt_reg;
  logic [scl_pkg::CNT_W-1:0]         soft_cnt_reg;
  logic                              reset_active;
  logic                              latch_now;
  logic                              soft_req;

  assign reset_active = ~pin_reg[scl_pkg::SP_RSTN] | (soft_cnt_reg != '0);
  assign latch_now    = (state_reg == scl_pkg::SCL_ST_SETTLE) & ~reset_active &
                        (settle_cnt_reg == scl_pkg::CNT_W'(scl_pkg::SETTLE_CYC - 1));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      scl_pkg::SCL_ST_HOLD: begin
        if (!reset_active) begin
          state_next = scl_pkg::SCL_ST_SETTLE;
        end
      end
      scl_pkg::SCL_ST_SETTLE: begin
        if (reset_active) begin
          state_next = scl_pkg::SCL_ST_HOLD;
        end else if (latch_now) begin
          state_next = scl_pkg::SCL_ST_RUN;
        end
      end
      scl_pkg::SCL_ST_RUN: begin
        if (reset_active) begin
          state_next = scl_pkg::SCL_ST_HOLD;
        end
      end
      default: begin
        state_next = scl_pkg::SCL_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= scl_pkg::SCL_ST_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || state_reg != scl_pkg::SCL_ST_SETTLE) begin
      settle_cnt_reg <= '0;
    end else begin
      settle_cnt_reg <= settle_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      soft_cnt_reg <= '0;
    end else if (soft_req) begin
      soft_cnt_reg <= scl_pkg::CNT_W'(scl_pkg::SOFT_RST_CYC);
    end else if (soft_cnt_reg != '0) begin
      soft_cnt_reg <= soft_cnt_reg - 1'b1;
    end
  end

  // Latched strap configuration, untouched outside the capture edge
  scl_pkg::scl_cfg_t strap_cfg_reg;

  always_ff @(posedge clk) begin
    if (srst) begin
      strap_cfg_reg <= scl_pkg::CFG_RESET;
    end else if (latch_now) begin
      strap_cfg_reg <= strap_dec;
    end
  end

  // APB slave
  logic [11:0] reg_idx;
  logic        hit_rstctl;
  logic        hit_lpcfg;
  logic        hit_sts;
  logic        hit_ov;
  logic        hit_any;
  logic        setup;
  logic        wr_fire;
  logic [31:0] rd_mux;
  logic        release_reg;
  logic [10:0] override_reg;
  logic        link_up_q_reg;
  logic        link_rise;
  logic        in_reset_state;

  assign reg_idx    = paddr[scl_pkg::ADDR_W-1:2];
  assign hit_rstctl = (paddr[1:0] == 2'h0) && (reg_idx == scl_pkg::IDX_RSTCTL) && (paddr[31:scl_pkg::ADDR_W] == '0);
  assign hit_lpcfg  = (paddr[1:0] == 2'h0) && (reg_idx == scl_pkg::IDX_LPCFG) && (paddr[31:scl_pkg::ADDR_W] == '0);
  assign hit_sts    = (paddr[1:0] == 2'h0) && (reg_idx == scl_pkg::IDX_STRAPSTS) && (paddr[31:scl_pkg::ADDR_W] == '0);
  assign hit_ov     = (paddr[1:0] == 2'h0) && (reg_idx == scl_pkg::IDX_OVERRIDE) && (paddr[31:scl_pkg::ADDR_W] == '0);
  assign hit_any    = hit_rstctl | hit_lpcfg | hit_sts | hit_ov;
  assign setup      = psel & ~penable;
  assign wr_fire    = psel & penable & pready & pwrite & hit_any & ~pslverr;
  assign soft_req   = wr_fire & hit_rstctl & pwdata[scl_pkg::RSTCTL_HW_BIT];
  assign link_rise  = link_up & ~link_up_q_reg;
  assign in_reset_state = (state_reg != scl_pkg::SCL_ST_RUN);

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_lpcfg) begin
      rd_mux[scl_pkg::LP_REL_BIT] = release_reg;
    end else if (hit_sts) begin
      rd_mux[9:0]  = strap_cfg_reg;
      rd_mux[11:10] = state_reg;
    end else if (hit_ov) begin
      rd_mux[10:0] = override_reg;
    end else if (hit_rstctl) begin
      rd_mux[scl_pkg::RSTCTL_HW_BIT] = (soft_cnt_reg != '0);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      link_up_q_reg <= 1'b0;
    end else begin
      link_up_q_reg <= link_up;
    end
  end

  // Release bit: software write wins over the link-up clear
  always_ff @(posedge clk) begin
    if (srst || in_reset_state) begin
      release_reg <= 1'b0;
    end else if (wr_fire && hit_lpcfg) begin
      release_reg <= pwdata[scl_pkg::LP_REL_BIT];
    end else if (link_rise) begin
      release_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || in_reset_state) begin
      override_reg <= '0;
    end else if (wr_fire && hit_ov) begin
      override_reg <= pwdata[10:0];
    end
  end

  // Effective configuration: straps unless overridden
  scl_pkg::scl_cfg_t eff_cfg;

  assign eff_cfg.station_addr_bits      = strap_cfg_reg.station_addr_bits;
  assign eff_cfg.clock_out_pin_select   = strap_cfg_reg.clock_out_pin_select;
  assign eff_cfg.host_if_select         = override_reg[scl_pkg::OV_EN_HOSTIF] ?
      scl_pkg::scl_hostif_t'(override_reg[scl_pkg::OV_HOSTIF_LSB +: 3]) : strap_cfg_reg.host_if_select;
  assign eff_cfg.leader_follower_select = override_reg[scl_pkg::OV_EN_ROLE] ?
      override_reg[scl_pkg::OV_ROLE_BIT] : strap_cfg_reg.leader_follower_select;
  assign eff_cfg.auto_disable           = override_reg[scl_pkg::OV_EN_AUTO] ?
      override_reg[scl_pkg::OV_AUTO_BIT] : strap_cfg_reg.auto_disable;

  // Registered outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      station_addr_bits      <= 4'h0;
      host_if_select         <= scl_pkg::SCL_IF_SERIAL;
      host_if_reserved       <= 1'b0;
      clock_out_pin_select   <= 1'b0;
      leader_follower_select <= 1'b0;
      auto_disable           <= 1'b0;
      link_start_enable      <= 1'b0;
      strap_phase            <= 1'b1;
    end else begin
      station_addr_bits      <= eff_cfg.station_addr_bits;
      host_if_select         <= eff_cfg.host_if_select;
      host_if_reserved       <= ~HAS_SERIAL & (eff_cfg.host_if_select == scl_pkg::SCL_IF_SERIAL);
      clock_out_pin_select   <= eff_cfg.clock_out_pin_select;
      leader_follower_select <= eff_cfg.leader_follower_select;
      auto_disable           <= eff_cfg.auto_disable;
      link_start_enable      <= ~in_reset_state & (~eff_cfg.auto_disable | release_reg);
      strap_phase            <= in_reset_state & (state_next != scl_pkg::SCL_ST_RUN);
    end
  end

  // Pin function swap; pins stay undriven while straps are sampled
  always_ff @(posedge clk) begin
    if (srst) begin
      clock_output_pin_o    <= 1'b0;
      indicator1_pin_o      <= 1'b0;
      clock_output_pin_oe_n <= 1'b1;
      indicator1_pin_oe_n   <= 1'b1;
    end else begin
      clock_output_pin_o    <= eff_cfg.clock_out_pin_select ? indicator1_src : clock_src;
      indicator1_pin_o      <= eff_cfg.clock_out_pin_select ? clock_src : indicator1_src;
      clock_output_pin_oe_n <= in_reset_state;
      indicator1_pin_oe_n   <= in_reset_state;
    end
  end

endmodule

// ### testbench/scl_strap_latch_sva.sv
module scl_strap_latch_sva (
  input logic        clk,
  input logic        srst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] paddr,
  input logic        pready,
  input logic        pslverr,
  input logic        reset_pin_n,
  input logic        clock_src,
  input logic        indicator1_src,
  input logic        indicator1_pin_o,
  input logic        indicator1_pin_oe_n,
  input logic        clock_output_pin_o,
  input logic        clock_output_pin_oe_n,
  input logic        strap_phase,
  input logic [3:0]  station_addr_bits,
  input logic        clock_out_pin_select,
  input logic        auto_disable,
  input logic        link_start_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] quiet_cnt;
  wire logic  rst_wr = psel && pwrite && paddr == 32'h7c;
  wire logic  rel_wr = psel && penable && pready && pwrite && paddr == 32'h62c;
  wire logic  run_ok = quiet_cnt >= 4'h3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Cycles settled in run, cleared by every reset cause
  always_ff @(posedge clk) begin
    if (srst || strap_phase || !reset_pin_n || rst_wr) begin
      quiet_cnt <= 4'h0;
    end else if (quiet_cnt != 4'hf) begin
      quiet_cnt <= quiet_cnt + 4'h1;
    end
  end
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_cfg_hold: assert property (run_ok |-> $stable(station_addr_bits) && $stable(clock_out_pin_select))
    else $error("latched straps moved");
  a_auto_link: assert property (run_ok && !auto_disable |-> link_start_enable)
    else $error("autonomous link start missing");
  a_managed_wait: assert property ($rose(link_start_enable) && auto_disable && run_ok
    |-> $past(rel_wr) || $past(rel_wr, 2) || $past(rel_wr, 3)) else $error("link start without release");
  a_release_go: assert property (rel_wr && run_ok |-> ##[1:3] link_start_enable)
    else $error("release did not start link");
  a_oe_phase: assert property ($rose(strap_phase) |=> indicator1_pin_oe_n && clock_output_pin_oe_n)
    else $error("pins driven while sampling");
  a_route_plain: assert property (run_ok && !clock_out_pin_select |-> clock_output_pin_o == $past(clock_src)
    && indicator1_pin_o == $past(indicator1_src)) else $error("plain pin routing wrong");
  a_route_swap: assert property (run_ok && clock_out_pin_select |-> clock_output_pin_o == $past(indicator1_src)
    && indicator1_pin_o == $past(clock_src)) else $error("swapped pin routing wrong");
  c_managed: cover property (run_ok && auto_disable && link_start_enable);
  c_swap: cover property (run_ok && clock_out_pin_select);
  c_error: cover property (pslverr);
endmodule

bind scl_strap_latch scl_strap_latch_sva scl_strap_latch_sva_i (.*);

// ### testbench/scl_strap_board.sv
module scl_strap_board (
  input  logic       clk,
  input  logic       strap_phase,
  input  logic [1:0] ctrl_mode,
  input  logic [1:0] er_mode,
  input  logic [3:0] rxd,
  input  logic       ind0,
  input  logic       ind1,
  input  logic       clkp,
  input  logic       indicator1_pin_o,
  input  logic       indicator1_pin_oe_n,
  input  logic       clock_output_pin_o,
  input  logic       clock_output_pin_oe_n,
  output logic       rx_ctrl_above_low,
  output logic       rx_ctrl_above_high,
  output logic       rx_er_above_low,
  output logic       rx_er_above_high,
  output logic [3:0] rx_data_strap,
  output logic       indicator0_pin_i,
  output logic       indicator1_pin_i,
  output logic       clock_output_pin_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic pat = 1'b0;
  // Functional traffic after sampling, never the strap level
  always_ff @(posedge clk) pat <= ~pat;
  assign rx_ctrl_above_low  = strap_phase ? ctrl_mode[1] : pat;
  assign rx_ctrl_above_high = strap_phase ? &ctrl_mode : ~pat;
  assign rx_er_above_low    = strap_phase ? er_mode[1] : pat;
  assign rx_er_above_high   = strap_phase ? &er_mode : ~pat;
  assign rx_data_strap      = strap_phase ? rxd : {4{pat}};
  assign indicator0_pin_i   = strap_phase ? ind0 : pat;
  // Released pins rest at their strap resistor level
  assign indicator1_pin_i   = indicator1_pin_oe_n ? ind1 : indicator1_pin_o;
  assign clock_output_pin_i = clock_output_pin_oe_n ? clkp : clock_output_pin_o;
endmodule

// ### testbench/scl_strap_latch_test.sv
module scl_strap_latch_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, reset_pin_n, link_up, err;
  logic        clock_src, indicator1_src, strap_phase, host_if_reserved, clock_out_pin_select;
  logic        leader_follower_select, auto_disable, link_start_enable, ind0, ind1, clkp;
  logic        rx_ctrl_above_low, rx_ctrl_above_high, rx_er_above_low, rx_er_above_high;
  logic        indicator0_pin_i, indicator1_pin_i, clock_output_pin_i, indicator1_pin_o;
  logic        indicator1_pin_oe_n, clock_output_pin_o, clock_output_pin_oe_n;
  logic [31:0] paddr, pwdata, prdata, rd, ov;
  logic [3:0]  rx_data_strap, station_addr_bits, rxd;
  logic [1:0]  ctrl_mode, er_mode;
  logic [15:0] seed;
  logic [11:0] e;
  int          miscompares, total_checks;
  scl_pkg::scl_hostif_t host_if_select;

  scl_strap_latch scl_strap_latch_i (.*);
  scl_strap_board scl_strap_board_i (.*);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    clock_src <= ~clock_src;
    indicator1_src <= clock_src ^ indicator1_src;
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [11:0] exp_status();
    logic [3:0] a;
    a = {er_mode >= 2'h2, ctrl_mode >= 2'h2, er_mode == 2'h3, ctrl_mode == 2'h3};
    return {2'h3, a, rxd[2:0], rxd[3], ind0, rxd[3] ? clkp : ind1};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      $display("[ERR] %s expected %h seen %h", nm, x, g);
      miscompares++;
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic x);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk("pready", 32'h1, 32'(pready));
    if (pready !== 1'b1) tally_and_finish();
    r = prdata;
    x = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (strap_phase !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk("strap_rise", 32'h1, 32'(strap_phase));
    if (strap_phase !== 1'b1) tally_and_finish();
    while (strap_phase !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("strap_phase", 32'h0, 32'(strap_phase));
    if (strap_phase !== 1'b0) tally_and_finish();
    repeat (8) @(posedge clk);
  endtask

  initial begin
    {srst, reset_pin_n} = 2'h3;
    {psel, penable, pwrite, link_up, clock_src, indicator1_src} = 6'h0;
    {paddr, pwdata, ctrl_mode, er_mode, rxd, ind0, ind1, clkp} = '0;
    {miscompares, total_checks} = '0;
    seed = 16'hd616;
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      seed = lfsr(seed);
      ctrl_mode <= 2'(i % 3 + 1);
      er_mode <= 2'(i / 3 + 1);
      rxd <= {i[1], i[2:0]};
      ind0 <= seed[1];
      ind1 <= seed[2];
      clkp <= ~seed[2];
      link_up <= 1'b0;
      if (i == 0) begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
      end else if (i % 3 == 2) begin
        apb(1'b1, 32'h7c, 32'h8000, rd, err);
      end else begin
        reset_pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        reset_pin_n <= 1'b1;
      end
      wait_run();
      e = exp_status();
      chk("addr", 32'(e[9:6]), 32'(station_addr_bits));
      chk("hostif", 32'(e[5:3]), 32'(host_if_select));
      chk("clksel", 32'(e[2]), 32'(clock_out_pin_select));
      chk("role", 32'(e[1]), 32'(leader_follower_select));
      chk("auto", 32'(e[0]), 32'(auto_disable));
      chk("oe_n", 32'h0, 32'(clock_output_pin_oe_n));
      chk("oe1_n", 32'h0, 32'(indicator1_pin_oe_n));
      chk("reserved", 32'h0, 32'(host_if_reserved));
      apb(1'b0, 32'h1174, 32'h0, rd, err);
      chk("status", 32'(e), rd);
      chk("lse", 32'(!e[0]), 32'(link_start_enable));
      if (e[0]) begin
        apb(1'b1, 32'h62c, 32'h40, rd, err);
        repeat (3) @(posedge clk);
        chk("lse", 32'h1, 32'(link_start_enable));
        apb(1'b0, 32'h62c, 32'h0, rd, err);
        chk("release", 32'h1, 32'(rd[6]));
        link_up <= 1'b1;
        repeat (2) @(posedge clk);
        apb(1'b0, 32'h62c, 32'h0, rd, err);
        chk("release", 32'h0, 32'(rd[6]));
      end
      $display("test %0d done", i);
    end
    // Register override of the host interface, role and auto-disable straps
    seed = lfsr(seed);
    ov = {21'h0, 3'h7, 3'h0, seed[4:0]};
    apb(1'b1, 32'h1180, ov, rd, err);
    chk("ov_err", 32'h0, 32'(err));
    repeat (2) @(posedge clk);
    chk("ov_hostif", 32'(ov[2:0]), 32'(host_if_select));
    chk("ov_role", 32'(ov[3]), 32'(leader_follower_select));
    chk("ov_auto", 32'(ov[4]), 32'(auto_disable));
    chk("ov_lse", 32'(!ov[4]), 32'(link_start_enable));
    apb(1'b0, 32'h1180, 32'h0, rd, err);
    chk("ov_read", ov, rd);
    $display("test override done");
    apb(1'b1, 32'h8, 32'h1, rd, err);
    chk("pslverr", 32'h1, 32'(err));
    apb(1'b0, 32'h1176, 32'h0, rd, err);
    chk("pslverr", 32'h1, 32'(err));
    chk("prdata", 32'h0, rd);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule
